// File: dv/raster_mask_sync_blockfill_test.sv
// Self-checking bench for the raster mask and block fill block
`include "rmsb_defs.svh"
`default_nettype none
`define SEEN rmsb_sink_inst.seen
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module raster_mask_sync_blockfill_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0, reset_in = 1'b1, msg_valid_in = 1'b0, y_down_in = 1'b0;
    logic        skip_right_in = 1'b0, mask_bit_order_in = 1'b0, mask_invert_in = 1'b0;
    logic [2:0]  msg_kind_in = 3'h0;
    logic [31:0] msg_data_in = 32'h0;
    logic [15:0] x_left_in = 16'h0, x_right_in = 16'h0, y_start_in = 16'h0, line_count_in = 16'h1;
    logic        msg_ready_out, out_valid_out, out_active_out, out_ready_in, busy_out, abort_out;
    logic [1:0]  out_kind_out;
    logic [31:0] out_data_out;
    int          n_mismatch = 0, compares = 0, n_abort = 0;
    rmsb_raster rmsb_raster_inst (.clk_in, .reset_in, .msg_valid_in, .msg_kind_in, .msg_data_in,
        .msg_ready_out, .x_left_in, .x_right_in, .y_start_in, .line_count_in, .y_down_in,
        .skip_right_in, .mask_bit_order_in, .mask_invert_in, .out_valid_out, .out_kind_out,
        .out_active_out, .out_data_out, .out_ready_in, .busy_out, .abort_out);
    rmsb_sink rmsb_sink_inst (.clk_in, .reset_in, .out_valid_in(out_valid_out),
        .out_kind_in(out_kind_out), .out_active_in(out_active_out),
        .out_data_in(out_data_out), .out_ready_out(out_ready_in));
    initial forever #12.5 clk_in = ~clk_in;
    always @(negedge clk_in) if (abort_out === 1'b1) n_abort++;
    task automatic results();
        $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic hang();
        n_mismatch++;
        results();
    endtask
    task automatic send(input logic [2:0] k, input logic [31:0] d);
        int i;
        @(posedge clk_in);
        msg_valid_in <= 1'b1;
        msg_kind_in <= k;
        msg_data_in <= d;
        for (i = 0; i < 500; i++) begin
            @(negedge clk_in);
            if (msg_ready_out === 1'b1) break;
        end
        if (i == 500) hang();
        @(posedge clk_in);
        msg_valid_in <= 1'b0;
    endtask
    task automatic wait_idle();
        int i;
        repeat (6) @(negedge clk_in);
        for (i = 0; i < 3000 && busy_out !== 1'b0; i++) @(negedge clk_in);
        if (i == 3000) hang();
        repeat (4) @(posedge clk_in);
    endtask
    task automatic geom(input int r, input int n, input logic s);
        @(posedge clk_in);
        x_right_in <= 16'(r);
        line_count_in <= 16'(n);
        skip_right_in <= s;
        y_start_in <= 16'h0005;
        `SEEN.delete();
    endtask
    task automatic t_mask();
        logic [31:0] p;
        p = 32'h5A3C00F1;
        for (int k = 0; k < 4; k++) begin
            geom(31, 1, 1'b0);
            mask_bit_order_in <= k[0];
            mask_invert_in <= k[1];
            send(`RMSB_MSG_MASK, p);
            send(`RMSB_MSG_RENDER, 32'h1000);
            wait_idle();
            `CHK("mask steps", 32, `SEEN.size())
            for (int i = 0; i < 32; i++) begin
                `CHK("mask active", (k[0] ? p[i] : p[31 - i]) ^ k[1], `SEEN[i][32])
                `CHK("mask x", 16'(i), `SEEN[i][15:0])
            end
        end
        mask_bit_order_in <= 1'b0;
        mask_invert_in <= 1'b0;
        $display("Test mask done");
    endtask
    task automatic t_stall();
        int a;
        a = n_abort;
        geom(1, 1, 1'b0);
        send(`RMSB_MSG_RENDER, 32'h1000);
        repeat (20) @(negedge clk_in);
        `CHK("stall steps", 0, `SEEN.size())
        `CHK("stall busy", 1'b1, busy_out)
        send(`RMSB_MSG_OTHER, 32'h0);
        wait_idle();
        `CHK("stall abort", 1, n_abort - a)
        $display("Test stall done");
    endtask
    task automatic t_paced();
        int a;
        geom(3, 1, 1'b0);
        send(`RMSB_MSG_RENDER, 32'h1800);
        repeat (10) @(negedge clk_in);
        `CHK("paced early", 0, `SEEN.size())
        for (int k = 0; k < 4; k++) begin
            if (k == 2) send(`RMSB_MSG_MASK, 32'hFFFFFFFF);
            send(3'(k), 32'h0);
            repeat (8) @(negedge clk_in);
            `CHK("paced steps", k + 1, `SEEN.size())
        end
        wait_idle();
        for (int i = 0; i < 4; i++) `CHK("paced active", i > 1, `SEEN[i][32])
        a = n_abort;
        geom(3, 1, 1'b0);
        send(`RMSB_MSG_RENDER, 32'h0800);
        send(`RMSB_MSG_FRAMEBUFFER_DATA_MSG, 32'h0);
        send(`RMSB_MSG_OTHER, 32'h0);
        wait_idle();
        `CHK("paced abort", 1, n_abort - a)
        `CHK("paced cut", 1, `SEEN.size())
        $display("Test paced done");
    endtask
    task automatic t_skip();
        geom(3, 1, 1'b1);
        send(`RMSB_MSG_RENDER, 32'h0);
        wait_idle();
        `CHK("skip steps", 3, `SEEN.size())
        `CHK("skip last", 32'h00050002, `SEEN[2][31:0])
        `CHK("walk kind", `RMSB_OUT_WALK, `SEEN[0][34:33])
        `CHK("walk active", 1'b1, `SEEN[0][32])
        $display("Test skip done");
    endtask
    task automatic t_fill();
        int s;
        logic [31:0] e;
        for (int c = 0; c < 3; c++) begin
            s = 8 << c;
            geom(63, 2, 1'b0);
            x_left_in <= 16'h0005;
            y_down_in <= c[0];
            send(`RMSB_MSG_RENDER, 32'h8 | (c << 4));
            wait_idle();
            `CHK("fill count", 2 * (64 / s) + 2, `SEEN.size())
            for (int j = 0; j <= 64 / s; j++) begin
                e = j ? {16'h0005, 16'((j - 1) * s)} : 32'h003F0005;
                `CHK("fill kind", j ? `RMSB_OUT_BLOCK : `RMSB_OUT_LIMITS, `SEEN[j][34:33])
                `CHK("fill data", e, `SEEN[j][31:0])
            end
            e = c[0] ? 32'h00040000 : 32'h00060000;
            `CHK("fill line two", e, `SEEN[64 / s + 2][31:0])
        end
        $display("Test fill done");
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        t_mask();
        t_stall();
        t_paced();
        t_skip();
        t_fill();
        results();
    end
endmodule
bind rmsb_raster rmsb_checker rmsb_checker_inst (.clk_in, .reset_in, .msg_valid_in,
    .msg_ready_out, .out_valid_out, .out_kind_out, .out_data_out, .out_ready_in, .busy_out,
    .abort_out);
`default_nettype wire

// File: dv/rmsb_checker.sv
// Port-level properties of the raster mask and block fill block
`include "rmsb_defs.svh"
`default_nettype none
module rmsb_checker (
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        reset_in,
    // Message handshake
    input wire logic        msg_valid_in,
    input wire logic        msg_ready_out,
    // Step messages and status
    input wire logic        out_valid_out,
    input wire logic [1:0]  out_kind_out,
    input wire logic [31:0] out_data_out,
    input wire logic        out_ready_in,
    input wire logic        busy_out,
    input wire logic        abort_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic taken;
    assign taken = msg_valid_in && msg_ready_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    chk_hold_step: assert property (out_valid_out && !out_ready_in |=>
        out_valid_out && $stable(out_data_out) && $stable(out_kind_out))
        else $error("step message changed before accepted");
    chk_abort_pulse: assert property (abort_out |=> !abort_out)
        else $error("abort longer than one cycle");
    chk_abort_idle: assert property (abort_out |-> ##[0:3] !busy_out)
        else $error("primitive still running after abort");
    chk_kind_legal: assert property (out_valid_out |-> out_kind_out != 2'h3)
        else $error("unknown output kind");
    chk_block_align: assert property (out_valid_out && out_kind_out == `RMSB_OUT_BLOCK
        |-> out_data_out[2:0] == 3'h0) else $error("block address not aligned");
    chk_limits_order: assert property (out_valid_out && out_kind_out == `RMSB_OUT_LIMITS
        |-> out_data_out[31:16] >= out_data_out[15:0]) else $error("limits reversed");
    chk_busy_cause: assert property ($rose(busy_out) |->
        $past(taken) || $past(taken, 2) || $past(taken, 3))
        else $error("busy without a message taken");
    chk_reset_quiet: assert property (disable iff (1'b0)
        reset_in |=> !out_valid_out && !busy_out && !abort_out)
        else $error("outputs active after reset");
endmodule
`default_nettype wire

// File: dv/rmsb_sink.sv
// Downstream partner: takes step messages with periodic back-pressure
`default_nettype none
module rmsb_sink (
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        reset_in,
    // Step messages
    input wire logic        out_valid_in,
    input wire logic [1:0]  out_kind_in,
    input wire logic        out_active_in,
    input wire logic [31:0] out_data_in,
    output logic            out_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  phase;
    logic [34:0] seen[$];
    // Stall one cycle in four so held outputs get exercised
    assign out_ready_out = (phase != 2'h3);
    always @(posedge clk_in) begin
        if (reset_in) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
            if (out_valid_in && out_ready_out) begin
                seen.push_back({out_kind_in, out_active_in, out_data_in});
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/rmsb_defs.svh
// Constants for the raster mask and block fill block
// Behaviour
// - Host pacing waits for data per pixel
// - Host pacing works for stepped spans only; block fill ignores it
// - Paced mode reloads mask on every word
// - Paced mode, exhausted mask gives passive fragments
// - Foreign message ends a host-paced primitive
// - Readback emits active walk steps
// - Copy scans destination rectangle only
// - One mask bit per generated pixel
// - Bit order follows mask bit order
// - Optional invert; one active, zero passive
// - Rotate mask one place per pixel
// - Unpaced, exhausted mask stalls for word
// - Right-edge pixel skipped, no mask bit
// - Block sizes 8, 16, 32, aligned starts
// - Block limits message at each scanline start
// - Block write per step, X by size
// - Block coordinates are screen relative
// - Block fill bypasses per-pixel operations
// - Block fill accepts any aligned trapezoid
// - Size code 0=8, 1=16, 2=32
// - Other message during stall aborts, then processed
`ifndef RMSB_DEFS_SVH
`define RMSB_DEFS_SVH
`define RMSB_MSG_COLOUR   3'h0
`define RMSB_MSG_DEPTH    3'h1
`define RMSB_MSG_STENCIL  3'h2
`define RMSB_MSG_FRAMEBUFFER_DATA_MSG   3'h3
`define RMSB_MSG_MASK     3'h4
`define RMSB_MSG_RENDER   3'h5
`define RMSB_MSG_OTHER    3'h6
`define RMSB_RND_FILL     3
`define RMSB_RND_SIZE_LO  4
`define RMSB_RND_PACED    11
`define RMSB_RND_MASKEN   12
`define RMSB_MODE_MIRROR  0
`define RMSB_MODE_INVERT  1
`define RMSB_MASK_BITS    6'h20
`define RMSB_OUT_WALK     2'h0
`define RMSB_OUT_LIMITS   2'h1
`define RMSB_OUT_BLOCK    2'h2
`endif

// File: rtl/rmsb_mask_bit.sv
// Mask bit selection, inversion and rotation
`include "rmsb_defs.svh"
`default_nettype none
module rmsb_mask_bit (
    // Mask and mode
    input  wire logic [31:0] mask_in,
    input  wire logic        mirror_in,
    input  wire logic        invert_in,
    // Result
    output logic             active_out,
    output logic [31:0]      rotated_out
);
    logic tested;
    always_comb begin
        tested = mirror_in ? mask_in[0] : mask_in[31];
        active_out = tested ^ invert_in;
        rotated_out = mirror_in ? {mask_in[0], mask_in[31:1]}
                                : {mask_in[30:0], mask_in[31]};
    end
endmodule
`default_nettype wire

// File: rtl/rmsb_pkg.sv
// Types shared by the raster mask and block fill block
`default_nettype none
package rmsb_pkg;
    typedef enum logic [2:0] {
        RMSB_IDLE,
        RMSB_LINE,
        RMSB_STEP,
        RMSB_WAIT_MASK,
        RMSB_FILL
    } rmsb_state_t;
endpackage
`default_nettype wire

// File: rtl/rmsb_raster.sv
// Rectangle/trapezoid span stepper with bit mask and fast block fill
`include "rmsb_defs.svh"
`default_nettype none
module rmsb_raster (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // Incoming message stream
    input  wire logic        msg_valid_in,
    input  wire logic [2:0]  msg_kind_in,
    input  wire logic [31:0] msg_data_in,
    output logic             msg_ready_out,
    // Primitive geometry (screen relative)
    input  wire logic [15:0] x_left_in,
    input  wire logic [15:0] x_right_in,
    input  wire logic [15:0] y_start_in,
    input  wire logic [15:0] line_count_in,
    input  wire logic        y_down_in,
    input  wire logic        skip_right_in,
    // Long-term mode
    input  wire logic        mask_bit_order_in,
    input  wire logic        mask_invert_in,
    // Outgoing step messages
    output logic             out_valid_out,
    output logic [1:0]       out_kind_out,
    output logic             out_active_out,
    output logic [31:0]      out_data_out,
    input  wire logic        out_ready_in,
    // Status
    output logic             busy_out,
    output logic             abort_out
);
    typedef struct packed {
        rmsb_pkg::rmsb_state_t state;
        logic        paced;
        logic        mask_en;
        logic        fill;
        logic [1:0]  size;
        logic [31:0] mask;
        logic [5:0]  bits_left;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] lines;
        logic        host_go;
        logic        pend_valid;
        logic [2:0]  pend_kind;
        logic [31:0] pend_data;
        logic        out_valid;
        logic [1:0]  out_kind;
        logic        out_active;
        logic [31:0] out_data;
        logic        abort;
        logic        busy;
        logic        ready;
    } rmsb_regs_t;

    rmsb_regs_t st_reg;
    rmsb_regs_t st_next;
    logic        bit_active;
    logic [31:0] bit_rot;
    logic [15:0] x_last;
    logic [15:0] step;
    logic        take;
    logic        host_data;
    logic        out_free;

    rmsb_mask_bit u_bit (
        .mask_in     (st_reg.mask),
        .mirror_in   (mask_bit_order_in),
        .invert_in   (mask_invert_in),
        .active_out  (bit_active),
        .rotated_out (bit_rot)
    );

    always_comb begin
        // With skip_right_in set, the right-edge pixel is outside the sampled span
        x_last = skip_right_in ? x_left_in + x_right_in - x_left_in - 16'h0001
                               : x_right_in;
        case (st_reg.size)
            2'h1: step = 16'h0010;
            2'h2: step = 16'h0020;
            default: step = 16'h0008;
        endcase
        out_free = !st_reg.out_valid || out_ready_in;
        host_data = st_reg.pend_kind == `RMSB_MSG_COLOUR
                 || st_reg.pend_kind == `RMSB_MSG_DEPTH
                 || st_reg.pend_kind == `RMSB_MSG_STENCIL
                 || st_reg.pend_kind == `RMSB_MSG_FRAMEBUFFER_DATA_MSG;
        // Ready is registered: one slot, refilled the cycle after it empties
        take = msg_valid_in && st_reg.ready;
        st_next = st_reg;
        st_next.abort = 1'b0;
        if (out_ready_in) begin
            st_next.out_valid = 1'b0;
        end
        // Messages are latched once, then acted on by the stepper
        if (take) begin
            st_next.pend_valid = 1'b1;
            st_next.pend_kind = msg_kind_in;
            st_next.pend_data = msg_data_in;
        end
        case (st_reg.state)
            rmsb_pkg::RMSB_IDLE: begin
                if (st_reg.pend_valid) begin
                    st_next.pend_valid = take;
                    if (st_reg.pend_kind == `RMSB_MSG_MASK) begin
                        st_next.mask = st_reg.pend_data;
                        st_next.bits_left = `RMSB_MASK_BITS;
                    end else if (st_reg.pend_kind == `RMSB_MSG_RENDER) begin
                        st_next.paced = st_reg.pend_data[`RMSB_RND_PACED];
                        st_next.mask_en = st_reg.pend_data[`RMSB_RND_MASKEN];
                        st_next.fill = st_reg.pend_data[`RMSB_RND_FILL];
                        st_next.size = st_reg.pend_data[`RMSB_RND_SIZE_LO +: 2];
                        st_next.y = y_start_in;
                        st_next.lines = line_count_in;
                        st_next.host_go = 1'b0;
                        st_next.state = line_count_in == 16'h0000 ? rmsb_pkg::RMSB_IDLE
                                                                 : rmsb_pkg::RMSB_LINE;
                    end
                end
            end
            rmsb_pkg::RMSB_LINE: begin
                if (out_free) begin
                    st_next.x = x_left_in;
                    if (st_reg.fill) begin
                        // Limits per line; addresses are screen relative
                        st_next.x = x_left_in & ~(step - 16'h0001);
                        st_next.out_valid = 1'b1;
                        st_next.out_kind = `RMSB_OUT_LIMITS;
                        st_next.out_active = 1'b1;
                        st_next.out_data = {x_last, x_left_in};
                        st_next.state = rmsb_pkg::RMSB_FILL;
                    end else begin
                        st_next.state = rmsb_pkg::RMSB_STEP;
                    end
                end
            end
            rmsb_pkg::RMSB_FILL: begin
                // No mask, pacing or per-pixel stages on this path
                if (out_free) begin
                    st_next.out_valid = 1'b1;
                    st_next.out_kind = `RMSB_OUT_BLOCK;
                    st_next.out_active = 1'b1;
                    st_next.out_data = {st_reg.y, st_reg.x};
                    st_next.x = st_reg.x + step;
                    if (st_reg.x + step > x_last) begin
                        st_next.y = y_down_in ? st_reg.y - 16'h0001 : st_reg.y + 16'h0001;
                        st_next.lines = st_reg.lines - 16'h0001;
                        st_next.state = st_reg.lines == 16'h0001 ? rmsb_pkg::RMSB_IDLE
                                                                : rmsb_pkg::RMSB_LINE;
                    end
                end
            end
            rmsb_pkg::RMSB_STEP: begin
                if (st_reg.paced && st_reg.pend_valid) begin
                    st_next.pend_valid = take;
                    if (st_reg.pend_kind == `RMSB_MSG_MASK) begin
                        st_next.mask = st_reg.pend_data;
                        st_next.bits_left = `RMSB_MASK_BITS;
                    end else if (host_data) begin
                        st_next.host_go = 1'b1;
                    end else begin
                        // Leave the message queued for idle handling
                        st_next.pend_valid = 1'b1;
                        st_next.abort = 1'b1;
                        st_next.state = rmsb_pkg::RMSB_IDLE;
                    end
                end else if (!st_reg.paced && st_reg.mask_en
                             && st_reg.bits_left == 6'h00) begin
                    st_next.state = rmsb_pkg::RMSB_WAIT_MASK;
                end else if ((!st_reg.paced || st_reg.host_go) && out_free) begin
                    st_next.host_go = 1'b0;
                    st_next.out_valid = 1'b1;
                    st_next.out_kind = `RMSB_OUT_WALK;
                    st_next.out_data = {st_reg.y, st_reg.x};
                    st_next.out_active = 1'b1;
                    if (st_reg.mask_en) begin
                        st_next.out_active = st_reg.bits_left != 6'h00 && bit_active;
                        if (st_reg.bits_left != 6'h00) begin
                            st_next.mask = bit_rot;
                            st_next.bits_left = st_reg.bits_left - 6'h01;
                        end
                    end
                    st_next.x = st_reg.x + 16'h0001;
                    if (st_reg.x >= x_last) begin
                        st_next.y = y_down_in ? st_reg.y - 16'h0001 : st_reg.y + 16'h0001;
                        st_next.lines = st_reg.lines - 16'h0001;
                        st_next.state = st_reg.lines == 16'h0001 ? rmsb_pkg::RMSB_IDLE
                                                                : rmsb_pkg::RMSB_LINE;
                    end
                end
            end
            rmsb_pkg::RMSB_WAIT_MASK: begin
                if (st_reg.pend_valid) begin
                    if (st_reg.pend_kind == `RMSB_MSG_MASK) begin
                        st_next.pend_valid = take;
                        st_next.mask = st_reg.pend_data;
                        st_next.bits_left = `RMSB_MASK_BITS;
                        st_next.state = rmsb_pkg::RMSB_STEP;
                    end else begin
                        st_next.abort = 1'b1;
                        st_next.state = rmsb_pkg::RMSB_IDLE;
                    end
                end
            end
            default: st_next.state = rmsb_pkg::RMSB_IDLE;
        endcase
        st_next.busy = st_next.state != rmsb_pkg::RMSB_IDLE;
        st_next.ready = !st_next.pend_valid;
        if (reset_in) begin
            st_next = '0;
            st_next.state = rmsb_pkg::RMSB_IDLE;
        end
    end

    always_ff @(posedge clk_in) begin
        st_reg <= st_next;
    end

    assign msg_ready_out  = st_reg.ready;
    assign out_valid_out  = st_reg.out_valid;
    assign out_kind_out   = st_reg.out_kind;
    assign out_active_out = st_reg.out_active;
    assign out_data_out   = st_reg.out_data;
    assign busy_out       = st_reg.busy;
    assign abort_out      = st_reg.abort;
endmodule
`default_nettype wire
